// file: verilog/msq_mode_reset_seq.sv
// Operating mode and reset source sequencer
// Function
// - After any reset start in init mode; change modes only on master command.
// - Run mode enables sampling, filtering, results, register access, pulses and interrupts.
// - Stop mode suspends all functions and ignores every master command.
// - Reading the stop trigger register enters stop as soon as the read completes.
// - Power-on reset in stop leaves stop, restores defaults, enters init mode.
// - Reset pin low in stop leaves stop; after release init with defaults.
// - Select falling in stop resumes metering without reset, keeping all registers.
// - Any command after stop entry wakes the device through its select falling edge.
// - Drive the reset pin low while an internal hardware reset source is active.
// - Reset pin must be low four current clocks; reset holds while low.
// - After external reset release clear all registers and continue in init mode.
// - Outside stop resume four current-clock cycles after external reset release.
// - Entering init clears low-power clock select, high-frequency clock before commands.
// - External reset released from stop waits 128 RC oscillator cycles.
// - Hold reset while power-on or brownout is active, then defaults and init.
// - Power-on or brownout reset forces low-power clock select to zero.
// - In stop brownout detection is off; only the power-on level resets.
// - Watchdog serviced automatically; expiry forces reset, pulses pin low, no flag.
// - Watchdog counter is halted throughout stop mode.
// - Writing one to soft reset bit clears registers and returns to init.
// - Soft reset leaves the reset pin undriven.
// - Reset pin has weak pull-up; internal reset holds it low until done.
`timescale 1ns/1ps
module msq_mode_reset_seq
	import msq_pkg::*;
#(
	parameter int unsigned WDT_TIMEOUT_CYC = WDT_TIMEOUT_DEFAULT
) (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        resetPinIn,
	output logic             resetPinOut,
	output logic             resetPinOe,
	input  wire logic        slaveSelectN,
	input  wire logic        brownoutTrip,
	input  wire logic        poweronTrip,
	input  wire logic        loopHeartbeat,
	input  wire logic        cmdValid,
	input  wire logic        cmdWrite,
	input  wire logic [11:0] cmdAddr,
	input  wire logic [7:0]  cmdWrData,
	output logic             cmdReady,
	output logic             rdValid,
	output logic [7:0]       rdData,
	output logic             inInit,
	output logic             inRun,
	output logic             inStop,
	output logic             meterEnable,
	output logic             coreReset,
	output logic             regClear,
	output logic             lowPowerClockSelect
);
	msq_state_t       state_r;
	msq_state_t       state_nxt;
	msq_src_t         holdSrc_r;
	msq_src_t         holdSrc_nxt;
	logic             holdFromStop_r;
	logic             holdFromStop_nxt;
	logic [CNT_W-1:0] waitCnt_r;
	logic [CNT_W-1:0] waitLen;
	logic [CNT_W-1:0] holdCnt_r;
	logic [EXT_W-1:0] extLowCnt_r;
	logic [EXT_W-1:0] extNeed;
	logic [31:0]      wdtCnt_r;
	logic [3:0]       driveHist_r;
	logic             pinLevel;
	logic             sselLevel;
	logic             borLevel;
	logic             porLevel;
	logic             sselPrev_r;
	logic             runBit_r;
	logic             low_power_clock_select_r;
	logic             porActive;
	logic             extActive;
	logic             wdtExpire;
	logic             take;
	logic             wrOp;
	logic             softReq;
	logic             stopReq;
	logic             sselFall;
	logic             enterWait;
	logic [7:0]       rd_nxt;
	logic [CNT_W-1:0] waitSeen_r;
	logic [CNT_W-1:0] waitTarget_r;

	// Pin inputs come from outside the clock domain
	msq_sync3 #(.RESET_LEVEL(1'b1)) u_syncResetPin (
		.clock (clock),
		.reset (reset),
		.pinIn (resetPinIn),
		.level (pinLevel)
	);
	msq_sync3 #(.RESET_LEVEL(1'b1)) u_syncSelect (
		.clock (clock),
		.reset (reset),
		.pinIn (slaveSelectN),
		.level (sselLevel)
	);
	msq_sync3 #(.RESET_LEVEL(1'b0)) u_syncBrownout (
		.clock (clock),
		.reset (reset),
		.pinIn (brownoutTrip),
		.level (borLevel)
	);
	msq_sync3 #(.RESET_LEVEL(1'b0)) u_syncPoweron (
		.clock (clock),
		.reset (reset),
		.pinIn (poweronTrip),
		.level (porLevel)
	);

	assign porActive = porLevel | (borLevel & (state_r != ST_STOP));
	assign extNeed   = ((state_r == ST_STOP) || low_power_clock_select_r) ? EXT_HOLD_LP_CYC : EXT_HOLD_HF_CYC;
	assign extActive = (extLowCnt_r >= extNeed);
	assign cmdReady  = (state_r == ST_INIT) || (state_r == ST_RUN);
	assign take      = cmdValid & cmdReady;
	assign wrOp      = take & cmdWrite & (cmdAddr == ADDR_OPERATING_MODE_REG_FIRST);
	assign softReq   = wrOp & cmdWrData[BIT_SOFT_RESET_REQUEST];
	assign stopReq   = take & ~cmdWrite & (cmdAddr == ADDR_STOP_TRIG);
	assign sselFall  = sselPrev_r & ~sselLevel;
	assign wdtExpire = cmdReady & ~loopHeartbeat & (wdtCnt_r == 32'(WDT_TIMEOUT_CYC - 1));
	assign enterWait = (state_nxt == ST_WAIT) && (state_r != ST_WAIT);

	// Mode and reset sequencing; hardware reset sources outrank every mode
	always_comb begin
		state_nxt        = state_r;
		holdSrc_nxt      = holdSrc_r;
		holdFromStop_nxt = holdFromStop_r;
		if (porActive) begin
			state_nxt        = ST_HOLD;
			holdSrc_nxt      = SRC_POR;
			holdFromStop_nxt = 1'b0;
		end else if (extActive) begin
			state_nxt   = ST_HOLD;
			holdSrc_nxt = SRC_EXT;
			if (state_r != ST_HOLD) begin
				holdFromStop_nxt = (state_r == ST_STOP);
			end
		end else if (wdtExpire) begin
			state_nxt        = ST_HOLD;
			holdSrc_nxt      = SRC_WDT;
			holdFromStop_nxt = 1'b0;
		end else begin
			case (state_r)
				ST_HOLD: begin
					if ((holdSrc_r != SRC_WDT) || (holdCnt_r == WDT_PULSE_CYC - CNT_ONE)) begin
						state_nxt = ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (waitCnt_r == CNT_ONE) begin
						state_nxt = ST_INIT;
					end
				end
				ST_INIT, ST_RUN: begin
					if (softReq) begin
						state_nxt        = ST_WAIT;
						holdSrc_nxt      = SRC_NONE;
						holdFromStop_nxt = 1'b0;
					end else if (stopReq) begin
						state_nxt = ST_STOP;
					end else if (wrOp) begin
						state_nxt = cmdWrData[BIT_RUN] ? ST_RUN : ST_INIT;
					end
				end
				ST_STOP: begin
					if (sselFall) begin
						state_nxt = ST_RUN;
					end
				end
				default: begin
					state_nxt = ST_WAIT;
				end
			endcase
		end
	end

	// Resume delay depends on where the reset came from and on the current clock
	always_comb begin
		if ((state_r == ST_HOLD) && holdFromStop_r) begin
			waitLen = STOP_WAKE_CYC;
		end else if (low_power_clock_select_r) begin
			waitLen = RESUME_LP_CYC;
		end else begin
			waitLen = RESUME_HF_CYC;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_r        <= ST_WAIT;
			holdSrc_r      <= SRC_POR;
			holdFromStop_r <= 1'b0;
		end else begin
			state_r        <= state_nxt;
			holdSrc_r      <= holdSrc_nxt;
			holdFromStop_r <= holdFromStop_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			waitCnt_r <= RESUME_HF_CYC;
		end else if (enterWait) begin
			waitCnt_r <= waitLen;
		end else if (state_r == ST_WAIT) begin
			waitCnt_r <= waitCnt_r - CNT_ONE;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			holdCnt_r <= CNT_ZERO;
		end else if (state_r == ST_HOLD) begin
			holdCnt_r <= holdCnt_r + CNT_ONE;
		end else begin
			holdCnt_r <= CNT_ZERO;
		end
	end

	// Own drive echoes back through the synchroniser, so the pin is ignored until that settles
	always_ff @(posedge clock) begin
		if (reset) begin
			driveHist_r <= HIST_CLEAR;
			extLowCnt_r <= EXT_ZERO;
		end else begin
			driveHist_r <= {driveHist_r[2:0], resetPinOe};
			if (!pinLevel && !resetPinOe && (driveHist_r == HIST_CLEAR)) begin
				if (extLowCnt_r != EXT_HOLD_LP_CYC) begin
					extLowCnt_r <= extLowCnt_r + EXT_ONE;
				end
			end else begin
				extLowCnt_r <= EXT_ZERO;
			end
		end
	end

	// Internal hardware sources pull the pin low; external and soft resets leave it alone
	always_ff @(posedge clock) begin
		if (reset) begin
			resetPinOe <= 1'b1;
		end else begin
			resetPinOe <= (state_nxt == ST_HOLD) && (holdSrc_nxt != SRC_EXT);
		end
	end
	assign resetPinOut = 1'b0;

	// Watchdog runs only while executing and freezes in stop
	always_ff @(posedge clock) begin
		if (reset) begin
			wdtCnt_r <= 32'h0;
		end else if (state_r == ST_STOP) begin
			wdtCnt_r <= wdtCnt_r;
		end else if (!cmdReady || loopHeartbeat || wdtExpire) begin
			wdtCnt_r <= 32'h0;
		end else begin
			wdtCnt_r <= wdtCnt_r + 32'h1;
		end
	end

	// First operating mode register; soft reset bit is an action and reads zero
	always_ff @(posedge clock) begin
		if (reset || enterWait) begin
			runBit_r <= 1'b0;
			low_power_clock_select_r  <= 1'b0;
		end else if (porActive) begin
			low_power_clock_select_r <= 1'b0;
		end else if ((state_nxt == ST_INIT) && (state_r != ST_INIT)) begin
			low_power_clock_select_r  <= 1'b0;
			runBit_r <= 1'b0;
		end else if (wrOp) begin
			runBit_r <= cmdWrData[BIT_RUN];
			low_power_clock_select_r  <= cmdWrData[BIT_LOW_POWER_CLOCK_SELECT];
		end
	end

	always_comb begin
		rd_nxt = RD_UNMAPPED;
		if (cmdAddr == ADDR_OPERATING_MODE_REG_FIRST) begin
			rd_nxt[BIT_RUN]          = runBit_r;
			rd_nxt[BIT_LOW_POWER_CLOCK_SELECT]        = low_power_clock_select_r;
			rd_nxt[STATE_LSB +: 3]   = state_r;
		end else if (cmdAddr == ADDR_STOP_TRIG) begin
			rd_nxt = STOP_TRIG_VALUE;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			rdValid    <= 1'b0;
			rdData     <= RD_UNMAPPED;
			regClear   <= 1'b1;
			sselPrev_r <= 1'b1;
		end else begin
			rdValid    <= take & ~cmdWrite;
			regClear   <= enterWait;
			sselPrev_r <= sselLevel;
			if (take && !cmdWrite) begin
				rdData <= rd_nxt;
			end
		end
	end

	assign lowPowerClockSelect = low_power_clock_select_r;
	assign inInit              = (state_r == ST_INIT);
	assign inRun               = (state_r == ST_RUN);
	assign inStop              = (state_r == ST_STOP);
	assign meterEnable         = (state_r == ST_RUN);
	assign coreReset           = (state_r == ST_HOLD) || (state_r == ST_WAIT);

	// Helper for checking the resume delay
	always_ff @(posedge clock) begin
		if (reset) begin
			waitSeen_r   <= CNT_ZERO;
			waitTarget_r <= RESUME_HF_CYC;
		end else if (enterWait) begin
			waitSeen_r   <= CNT_ZERO;
			waitTarget_r <= waitLen;
		end else if (state_r == ST_WAIT) begin
			waitSeen_r <= waitSeen_r + CNT_ONE;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	property p_run_by_cmd;
		(state_r != ST_RUN) ##1 (state_r == ST_RUN) |-> $past(wrOp) || $past(state_r == ST_STOP);
	endproperty
	a_run_by_cmd: assert property (p_run_by_cmd) else $error("run entered without command");

	property p_stop_deaf;
		(state_r == ST_STOP) |-> !cmdReady ##1 !rdValid;
	endproperty
	a_stop_deaf: assert property (p_stop_deaf) else $error("command served in stop");

	property p_stop_entry;
		stopReq && !porActive && !extActive && !wdtExpire |=> (state_r == ST_STOP) && rdValid && (rdData == STOP_TRIG_VALUE);
	endproperty
	a_stop_entry: assert property (p_stop_entry) else $error("stop not entered after trigger read");

	property p_stop_wake;
		(state_r == ST_STOP) && sselFall && !porActive && !extActive |=> (state_r == ST_RUN) && !regClear;
	endproperty
	a_stop_wake: assert property (p_stop_wake) else $error("select did not wake without reset");

	property p_por_drive;
		porActive |=> resetPinOe && (state_r == ST_HOLD) && !low_power_clock_select_r;
	endproperty
	a_por_drive: assert property (p_por_drive) else $error("power-on reset not driving pin");

	property p_ext_hold;
		(state_r == ST_HOLD) && (holdSrc_r == SRC_EXT) && extActive |=> (state_r == ST_HOLD);
	endproperty
	a_ext_hold: assert property (p_ext_hold) else $error("left reset while pin held low");

	property p_resume_delay;
		$rose(state_r == ST_INIT) && $past(state_r == ST_WAIT) |-> (waitSeen_r == waitTarget_r);
	endproperty
	a_resume_delay: assert property (p_resume_delay) else $error("resume delay wrong");

	property p_init_clock;
		$rose(state_r == ST_INIT) |-> !lowPowerClockSelect;
	endproperty
	a_init_clock: assert property (p_init_clock) else $error("init entered on low-power clock");

	property p_wdt_pulse;
		wdtExpire && !porActive && !extActive |=> resetPinOe [*8] ##1 !resetPinOe;
	endproperty
	a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog pulse length wrong");

	property p_wdt_halt;
		(state_r == ST_STOP) |=> $stable(wdtCnt_r);
	endproperty
	a_wdt_halt: assert property (p_wdt_halt) else $error("watchdog ran in stop");

	property p_soft_quiet;
		softReq && !porActive && !extActive && !wdtExpire |=> (state_r == ST_WAIT) && regClear && !resetPinOe ##1 (!resetPinOe) [*3];
	endproperty
	a_soft_quiet: assert property (p_soft_quiet) else $error("soft reset drove pin");

endmodule : msq_mode_reset_seq

// file: verilog/msq_pkg.sv
// Constants, register map and types shared by the mode and reset sequencer
package msq_pkg;

	// Clock rates: system clock and internal RC oscillator
	localparam int unsigned SYS_HZ              = 10_000_000;
	localparam int unsigned RC_HZ               = 1_000_000;
	localparam int unsigned RC_RATIO            = (SYS_HZ + RC_HZ - 1) / RC_HZ;

	// Timing figures as given, in their own units
	localparam int unsigned EXT_HOLD_CLKS       = 4;
	localparam int unsigned RESUME_CLKS         = 4;
	localparam int unsigned STOP_WAKE_US        = 128;
	localparam int unsigned WDT_PULSE_CLKS      = 8;
	localparam int unsigned WDT_TIMEOUT_DEFAULT = 65_536;

	// Counter widths
	localparam int          CNT_W               = 11;
	localparam int          EXT_W               = 6;

	// Derived cycle counts at the system clock rate, least times rounded up
	localparam logic [EXT_W-1:0] EXT_HOLD_HF_CYC = EXT_W'(EXT_HOLD_CLKS);
	localparam logic [EXT_W-1:0] EXT_HOLD_LP_CYC = EXT_W'(EXT_HOLD_CLKS * RC_RATIO);
	localparam logic [EXT_W-1:0] EXT_ZERO        = EXT_W'(0);
	localparam logic [EXT_W-1:0] EXT_ONE         = EXT_W'(1);
	localparam logic [CNT_W-1:0] RESUME_HF_CYC   = CNT_W'(RESUME_CLKS);
	localparam logic [CNT_W-1:0] RESUME_LP_CYC   = CNT_W'(RESUME_CLKS * RC_RATIO);
	localparam logic [CNT_W-1:0] STOP_WAKE_CYC   = CNT_W'((STOP_WAKE_US * SYS_HZ + 999_999) / 1_000_000);
	localparam logic [CNT_W-1:0] WDT_PULSE_CYC   = CNT_W'(WDT_PULSE_CLKS);
	localparam logic [CNT_W-1:0] CNT_ZERO        = CNT_W'(0);
	localparam logic [CNT_W-1:0] CNT_ONE         = CNT_W'(1);

	// Register map
	localparam logic [11:0] ADDR_OPERATING_MODE_REG_FIRST    = 12'hC00;
	localparam logic [11:0] ADDR_STOP_TRIG  = 12'hC02;
	localparam int          BIT_RUN         = 0;
	localparam int          BIT_LOW_POWER_CLOCK_SELECT       = 1;
	localparam int          BIT_SOFT_RESET_REQUEST       = 3;
	localparam int          STATE_LSB       = 5;
	localparam logic [7:0]  STOP_TRIG_VALUE = 8'h00;
	localparam logic [7:0]  RD_UNMAPPED     = 8'h00;
	localparam logic [3:0]  HIST_CLEAR      = 4'h0;

	typedef enum logic [2:0] {
		ST_HOLD = 3'h0,
		ST_WAIT = 3'h1,
		ST_INIT = 3'h2,
		ST_RUN  = 3'h3,
		ST_STOP = 3'h4
	} msq_state_t;

	typedef enum logic [1:0] {
		SRC_NONE = 2'h0,
		SRC_EXT  = 2'h1,
		SRC_POR  = 2'h2,
		SRC_WDT  = 2'h3
	} msq_src_t;

endpackage : msq_pkg

// file: verilog/msq_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module msq_sync3 #(
	parameter logic RESET_LEVEL = 1'b1
) (
	input  wire logic clock,
	input  wire logic reset,
	input  wire logic pinIn,
	output logic      level
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// First stage feeds only the second; the filter looks at stages two and three
	always_ff @(posedge clock) begin
		if (reset) begin
			s1_r  <= RESET_LEVEL;
			s2_r  <= RESET_LEVEL;
			s3_r  <= RESET_LEVEL;
			level <= RESET_LEVEL;
		end else begin
			s1_r <= pinIn;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				level <= s3_r;
			end
		end
	end
endmodule : msq_sync3

// file: tb/msq_master_model.sv
// Master side of the reset line: open-drain pull with weak pull-up
`timescale 1ns/1ps
module msq_master_model #(
	parameter int MIN_LOW = 8
) (
	input  wire logic clock,
	input  wire logic resetPinOe,
	input  wire logic resetPinOut,
	input  wire logic pullLow,
	output logic      resetWire
);
	int holdCnt;

	initial holdCnt = 0;

	// Even a one-cycle request is stretched so the pull outlasts the device filter on the high-frequency clock
	always @(posedge clock) begin
		if (pullLow) begin
			holdCnt <= MIN_LOW;
		end else if (holdCnt > 0) begin
			holdCnt <= holdCnt - 1;
		end
	end

	// Either party pulls low, otherwise the pull-up wins
	assign resetWire = (pullLow || holdCnt > 0) ? 1'b0 : (resetPinOe ? resetPinOut : 1'b1);
endmodule : msq_master_model

// file: tb/mode_and_reset_sequencer_bench.sv
// Self-checking bench for the mode and reset sequencer
`timescale 1ns/1ps
module mode_and_reset_sequencer_bench;
	import msq_pkg::*;
	localparam int unsigned WDT = 64;
	logic        clock;
	logic        reset;
	logic        pullLow;
	logic        resetWire;
	logic        resetPinOe;
	logic        resetPinOut;
	logic        slaveSelectN;
	logic        brownoutTrip;
	logic        poweronTrip;
	logic        loopHeartbeat;
	logic        hbOn;
	logic [3:0]  hbCnt;
	logic        cmdValid;
	logic        cmdWrite;
	logic [11:0] cmdAddr;
	logic [7:0]  cmdWrData;
	logic        cmdReady;
	logic        rdValid;
	logic [7:0]  rdData;
	logic        inInit;
	logic        inRun;
	logic        inStop;
	logic        meterEnable;
	logic        coreReset;
	logic        regClear;
	logic        lowPowerClockSelect;
	int          errors;
	int          checked;
	int          n;

	msq_mode_reset_seq #(.WDT_TIMEOUT_CYC(WDT)) DUT (
		.clock(clock), .reset(reset), .resetPinIn(resetWire), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
		.slaveSelectN(slaveSelectN), .brownoutTrip(brownoutTrip), .poweronTrip(poweronTrip),
		.loopHeartbeat(loopHeartbeat), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
		.cmdWrData(cmdWrData), .cmdReady(cmdReady), .rdValid(rdValid), .rdData(rdData),
		.inInit(inInit), .inRun(inRun), .inStop(inStop), .meterEnable(meterEnable),
		.coreReset(coreReset), .regClear(regClear), .lowPowerClockSelect(lowPowerClockSelect)
	);

	msq_master_model master (
		.clock(clock), .resetPinOe(resetPinOe), .resetPinOut(resetPinOut), .pullLow(pullLow),
		.resetWire(resetWire)
	);

	always #50 clock = ~clock;

	// Processing loop heartbeat, well inside the watchdog period
	always @(posedge clock) begin
		#1;
		hbCnt <= hbCnt + 4'h1;
		loopHeartbeat <= hbOn && (hbCnt == 4'hF);
	end

	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int c);
		repeat (c) @(posedge clock);
		#1;
	endtask : tick

	function automatic logic pick(input int s);
		case (s)
			0: return cmdReady;
			1: return resetPinOe;
			2: return inInit & cmdReady;
			default: return regClear;
		endcase
	endfunction : pick

	// Bounded wait; the cycle count comes back in c
	task automatic waitFor(input int s, input int lim, output int c);
		c = 0;
		while (pick(s) !== 1'b1) begin
			tick(1);
			c++;
			if (c > lim) begin
				errors++;
				$display("[ERR] t=%0t got=%h exp=%h", $time, pick(s), 1'b1);
				end_of_test;
			end
		end
	endtask : waitFor

	task automatic access(input logic w, input logic [11:0] a, input logic [7:0] d);
		int c;
		// An idle edge first, so back-to-back calls never reassign cmdValid in one time step
		tick(1);
		cmdValid = 1'b1;
		cmdWrite = w;
		cmdAddr = a;
		cmdWrData = d;
		waitFor(0, 2000, c);
		tick(1);
		cmdValid = 1'b0;
	endtask : access

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		access(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		access(1'b0, a, 8'h00);
		chk({7'h00, rdValid}, 8'h01);
		chk(rdData, exp);
	endtask : rd

	initial begin
		clock = 1'b0;
		reset = 1'b1;
		pullLow = 1'b0;
		slaveSelectN = 1'b1;
		brownoutTrip = 1'b0;
		poweronTrip = 1'b0;
		hbOn = 1'b1;
		hbCnt = 4'h0;
		loopHeartbeat = 1'b0;
		cmdValid = 1'b0;
		cmdWrite = 1'b0;
		cmdAddr = 12'h000;
		cmdWrData = 8'h00;
		errors = 0;
		checked = 0;
		tick(8);
		reset = 1'b0;
		waitFor(2, 100, n);
		chk({7'h00, lowPowerClockSelect}, 8'h00);
		rd(ADDR_OPERATING_MODE_REG_FIRST, 8'h40);
		rd(12'hFFF, RD_UNMAPPED);
		wr(ADDR_OPERATING_MODE_REG_FIRST, 8'h03);
		chk({6'h00, lowPowerClockSelect, meterEnable}, 8'h03);
		tick(3 * WDT);
		chk({6'h00, inRun, resetPinOe}, 8'h02);
		rd(ADDR_STOP_TRIG, STOP_TRIG_VALUE);
		chk({5'h00, inStop, meterEnable, cmdReady}, 8'h04);
		// Starve the watchdog and drop below brownout: stop must hold through both
		hbOn = 1'b0;
		brownoutTrip = 1'b1;
		tick(3 * WDT);
		chk({6'h00, inStop, resetPinOe}, 8'h02);
		brownoutTrip = 1'b0;
		hbOn = 1'b1;
		slaveSelectN = 1'b0;
		tick(6);
		chk({5'h00, inRun, lowPowerClockSelect, coreReset}, 8'h06);
		slaveSelectN = 1'b1;
		tick(6);
		rd(ADDR_OPERATING_MODE_REG_FIRST, 8'h63);
		wr(ADDR_OPERATING_MODE_REG_FIRST, 8'h08);
		chk({4'h0, coreReset, regClear, resetPinOe, lowPowerClockSelect}, 8'h0C);
		waitFor(2, 100, n);
		chk(8'(n), 8'(RESUME_CLKS * RC_RATIO));
		rd(ADDR_OPERATING_MODE_REG_FIRST, 8'h40);
		wr(ADDR_OPERATING_MODE_REG_FIRST, 8'h01);
		pullLow = 1'b1;
		tick(20);
		chk({6'h00, coreReset, resetPinOe}, 8'h02);
		pullLow = 1'b0;
		waitFor(3, 100, n);
		waitFor(2, 100, n);
		chk(8'(n), 8'(RESUME_CLKS));
		rd(ADDR_OPERATING_MODE_REG_FIRST, 8'h40);
		wr(ADDR_OPERATING_MODE_REG_FIRST, 8'h01);
		rd(ADDR_STOP_TRIG, STOP_TRIG_VALUE);
		pullLow = 1'b1;
		tick(50);
		pullLow = 1'b0;
		waitFor(3, 100, n);
		waitFor(2, 1600, n);
		chk(8'(n), 8'(STOP_WAKE_US * RC_RATIO));
		chk(8'(n >> 8), 8'((STOP_WAKE_US * RC_RATIO) >> 8));
		wr(ADDR_OPERATING_MODE_REG_FIRST, 8'h03);
		brownoutTrip = 1'b1;
		tick(6);
		chk({4'h0, resetWire, resetPinOe, coreReset, lowPowerClockSelect}, 8'h06);
		brownoutTrip = 1'b0;
		waitFor(2, 100, n);
		rd(ADDR_OPERATING_MODE_REG_FIRST, 8'h40);
		wr(ADDR_OPERATING_MODE_REG_FIRST, 8'h01);
		rd(ADDR_STOP_TRIG, STOP_TRIG_VALUE);
		poweronTrip = 1'b1;
		tick(6);
		chk({6'h00, inStop, coreReset}, 8'h01);
		poweronTrip = 1'b0;
		waitFor(2, 100, n);
		rd(ADDR_OPERATING_MODE_REG_FIRST, 8'h40);
		wr(ADDR_OPERATING_MODE_REG_FIRST, 8'h01);
		hbOn = 1'b0;
		waitFor(1, WDT + 40, n);
		n = 0;
		while (resetPinOe === 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
		chk(8'(n), 8'h08);
		hbOn = 1'b1;
		waitFor(2, 100, n);
		rd(ADDR_OPERATING_MODE_REG_FIRST, 8'h40);
		// Run back to init by command while asking for low power: init still lands on the fast clock
		wr(ADDR_OPERATING_MODE_REG_FIRST, 8'h03);
		wr(ADDR_OPERATING_MODE_REG_FIRST, 8'h02);
		rd(ADDR_OPERATING_MODE_REG_FIRST, 8'h40);
		end_of_test;
	end
endmodule : mode_and_reset_sequencer_bench
